// file: verilog/stl_params.svh
// Notes on behaviour
// - status bit 6 is OR of enabled bits
// - enable mask bit 6 is never stored
// - serial poll clears service request, summary stays
// - status query leaves the status byte unchanged
// - serial poll returns service request in bit 6
// - status byte bit layout is fixed
// - enable mask query returns the stored mask
// - armed trigger applies preloaded levels, clears armed unless continuous
// - continuous arming rearms right after each trigger
// - triggers act only while addressed as listener
// - self-test checks memory, returns 0 or 1
// - self-test drives the voltage level full scale positive then negative
// - wait command holds later commands until idle
// - event status read clears the register
// - unknown command sets command error bit 5
// - operation complete sets bit 0 when idle
// - power-up sets event status bit 7
// - empty status byte reads as zero
// - event summary is OR of enabled events
// - event status bit layout is fixed
// - single arming allows exactly one trigger
`ifndef STL_PARAMS_SVH
`define STL_PARAMS_SVH

// clock and self-test timing
`define STL_CLK_MHZ 20
`define STL_FS_HOLD_US 1000

// status byte fields
`define STL_STB_OPERATION_SUMMARY 7
`define STL_STB_MSS 6
`define STL_STB_ESB 5
`define STL_STB_MAV 4
`define STL_STB_QUESTIONABLE_SUMMARY 3
`define STL_STB_ERRQ 2

// event status fields
`define STL_ESR_PON 7
`define STL_ESR_CME 5
`define STL_ESR_EXE 4
`define STL_ESR_DDE 3
`define STL_ESR_QYE 2
`define STL_ESR_OPC 0

// reset values and fixed answers
`define STL_ESR_RST 8'h80
`define STL_ESE_RST 8'h00
`define STL_SRE_RST 8'h00
`define STL_SRE_WMASK 8'hBF
`define STL_TST_PASS 8'h00
`define STL_TST_FAIL 8'h01
`define STL_OPCQ_DONE 8'h01
`define STL_CRC_POLY 8'h07
`define STL_CRC_INIT 8'h00

`endif

// file: verilog/stl_pkg.sv
package stl_pkg;

  // command codes presented on the command port
  typedef enum logic [4:0] {
    CMD_CLS = 5'h01,
    CMD_ESE = 5'h02,
    CMD_ESE_Q = 5'h03,
    CMD_ESR_Q = 5'h04,
    CMD_OPC = 5'h05,
    CMD_OPC_Q = 5'h06,
    CMD_RST = 5'h07,
    CMD_SRE = 5'h08,
    CMD_SRE_Q = 5'h09,
    CMD_STB_Q = 5'h0A,
    CMD_TRG = 5'h0B,
    CMD_TST_Q = 5'h0C,
    CMD_WAI = 5'h0D,
    CMD_INIT = 5'h0E,
    CMD_INIT_CONT = 5'h0F,
    CMD_INIT_CONT_Q = 5'h10
  } stl_cmd_t;

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAIT_DONE = 3'b001,
    ST_OPCQ_WAIT = 3'b010,
    ST_TST_POS = 3'b011,
    ST_TST_NEG = 3'b100,
    ST_TST_CRC = 3'b101
  } stl_state_t;

endpackage : stl_pkg

// file: verilog/stl_crc8.sv
`timescale 1ns/1ns
`include "stl_params.svh"
module stl_crc8 #(
  parameter logic [7:0] POLY = `STL_CRC_POLY
) (
  input wire logic sys_clk_in, // system clock
  input wire logic rst_n_in, // sync reset, active low
  input wire logic clr_in, // restart the checksum
  input wire logic en_in, // absorb data_in this cycle
  input wire logic [7:0] data_in, // byte to absorb
  output logic [7:0] crc_out // running checksum
);

  logic [7:0] next_crc;

  // msb-first byte step; residue is zero when stored check byte matches
  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ POLY) : (r << 1);
    end
    return r;
  endfunction : crc_step

  // clear wins over absorb
  always_comb begin
    next_crc = crc_out;
    if (clr_in) begin
      next_crc = `STL_CRC_INIT;
    end else if (en_in) begin
      next_crc = crc_step(crc_out, data_in);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      crc_out <= `STL_CRC_INIT;
    end else begin
      crc_out <= next_crc;
    end
  end

endmodule : stl_crc8

// file: verilog/stl_status_trigger.sv
`timescale 1ns/1ns
`include "stl_params.svh"
module stl_status_trigger import stl_pkg::*; #(
  parameter int NVM_DEPTH = 256, // bytes covered by the self-test check
  parameter int NVM_AW = 8, // memory address width
  parameter int FS_HOLD_CYCLES = `STL_FS_HOLD_US * `STL_CLK_MHZ, // full-scale dwell per polarity
  parameter int CNT_W = 16, // sequencer counter width
  parameter int LVL_W = 16 // output level width
) (
  input wire logic sys_clk_in, // 20 MHz system clock
  input wire logic rst_n_in, // sync reset, active low
  input wire logic cmd_valid_in, // command present
  input wire logic [4:0] cmd_code_in, // command code
  input wire logic [7:0] cmd_data_in, // command argument
  output logic cmd_ready_out, // command accepted when high
  input wire logic listener_addr_in, // addressed as listener
  input wire logic bus_trigger_in, // group execute trigger pulse
  input wire logic serial_poll_in, // serial poll read pulse
  input wire logic ops_busy_in, // earlier operations still running
  input wire logic exec_error_in, // execution error pulse
  input wire logic dev_error_in, // device-dependent error pulse
  input wire logic query_error_in, // query error pulse
  input wire logic operation_summary_in, // operation summary level
  input wire logic msg_avail_in, // message available level
  input wire logic questionable_summary_in, // questionable summary level
  input wire logic error_queue_nonempty_in, // error queue not empty level
  input wire logic [LVL_W-1:0] trig_volt_in, // preloaded triggered voltage
  input wire logic [LVL_W-1:0] trig_curr_in, // preloaded triggered current
  input wire logic [7:0] nvm_data_in, // memory byte, one cycle after address
  output logic [NVM_AW-1:0] nvm_addr_out, // memory read address
  output logic resp_valid_out, // query answer pulse
  output logic [7:0] resp_data_out, // query answer value
  output logic poll_valid_out, // serial poll answer pulse
  output logic [7:0] poll_data_out, // serial poll status byte
  output logic [7:0] status_summary_byte_out, // live status byte
  output logic srq_out, // service request flag
  output logic trigger_armed_waiting_out, // trigger armed
  output logic [LVL_W-1:0] volt_level_out, // voltage level to output stage
  output logic [LVL_W-1:0] curr_level_out, // current level to output stage
  output logic level_apply_out, // levels changed pulse
  output logic test_active_out // self-test running
);

  // parameters the sequencer cannot serve
  if (FS_HOLD_CYCLES < 1 || FS_HOLD_CYCLES >= 2 ** CNT_W || NVM_DEPTH < 1 || NVM_DEPTH + 2 >= 2 ** CNT_W ||
      2 ** NVM_AW < NVM_DEPTH || LVL_W < 2) begin : g_bad_params
    $error("stl_status_trigger: unsupported parameter values");
  end

  localparam logic [LVL_W-1:0] FS_POS = {1'b0, {(LVL_W - 1){1'b1}}};
  localparam logic [LVL_W-1:0] FS_NEG = {1'b1, {(LVL_W - 1){1'b0}}};
  localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(FS_HOLD_CYCLES - 1);
  localparam logic [CNT_W-1:0] CRC_LAST = CNT_W'(NVM_DEPTH + 1);
  localparam logic [CNT_W-1:0] CRC_DATA_END = CNT_W'(NVM_DEPTH);

  logic cmd_take;
  logic known;
  logic busy_all;
  logic [7:0] base;
  logic mss;
  logic mss_rise;
  logic [7:0] esr_set;
  logic fire;
  logic crc_clr;
  logic crc_en;
  logic [7:0] crc_val;

  logic [7:0] esr, next_esr;
  logic [7:0] ese, next_ese;
  logic [7:0] service_request_mask, next_sre;
  logic opc_pend, next_opc_pend;
  logic [7:0] next_stb;
  logic next_rqs;
  logic next_poll_valid;
  logic [7:0] next_poll_data;

  stl_state_t state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic cont, next_cont;
  logic next_armed;
  logic [LVL_W-1:0] saved_volt, next_saved_volt;
  logic [LVL_W-1:0] next_volt, next_curr;
  logic next_apply;
  logic next_resp_valid;
  logic [7:0] next_resp_data;
  logic next_ready;
  logic [NVM_AW-1:0] next_nvm_addr;
  logic next_test_active;

  assign cmd_take = cmd_valid_in && cmd_ready_out;
  assign busy_all = ops_busy_in || test_active_out;

  // codes outside the command set count as unrecognized
  always_comb begin
    unique case (cmd_code_in)
      CMD_CLS, CMD_ESE, CMD_ESE_Q, CMD_ESR_Q, CMD_OPC, CMD_OPC_Q, CMD_RST, CMD_SRE, CMD_SRE_Q,
      CMD_STB_Q, CMD_TRG, CMD_TST_Q, CMD_WAI, CMD_INIT, CMD_INIT_CONT, CMD_INIT_CONT_Q: known = 1'b1;
      default: known = 1'b0;
    endcase
  end

  // status byte source bits; bit 6 held out of its own OR
  always_comb begin
    base = 8'h00; // unused bits 1 and 0 stay zero
    base[`STL_STB_OPERATION_SUMMARY] = operation_summary_in;
    base[`STL_STB_ESB] = |(esr & ese);
    base[`STL_STB_MAV] = msg_avail_in;
    base[`STL_STB_QUESTIONABLE_SUMMARY] = questionable_summary_in;
    base[`STL_STB_ERRQ] = error_queue_nonempty_in;
    mss = |(base & service_request_mask);
    mss_rise = mss && !status_summary_byte_out[`STL_STB_MSS];
  end

  // status registers: event status, masks, service request, poll answer
  always_comb begin
    esr_set = 8'h00;
    esr_set[`STL_ESR_CME] = cmd_take && !known;
    esr_set[`STL_ESR_EXE] = exec_error_in;
    esr_set[`STL_ESR_DDE] = dev_error_in;
    esr_set[`STL_ESR_QYE] = query_error_in;
    esr_set[`STL_ESR_OPC] = opc_pend && !busy_all;
    next_esr = esr;
    next_ese = ese;
    next_sre = service_request_mask;
    next_opc_pend = opc_pend;
    if (opc_pend && !busy_all) begin
      next_opc_pend = 1'b0;
    end
    if (cmd_take) begin
      unique case (cmd_code_in)
        CMD_CLS: begin
          next_esr = 8'h00;
          next_opc_pend = 1'b0;
        end
        CMD_ESR_Q: next_esr = 8'h00;
        CMD_ESE: next_ese = cmd_data_in;
        CMD_SRE: next_sre = cmd_data_in & `STL_SRE_WMASK;
        CMD_OPC: next_opc_pend = 1'b1; // no hold-off, just remembered
        default: ;
      endcase
    end
    next_esr = next_esr | esr_set; // a new event beats a same-cycle clear
    next_stb = base;
    next_stb[`STL_STB_MSS] = mss;
    // summary stays while its causes stand; only the request flag is consumed
    next_rqs = mss_rise || (srq_out && !serial_poll_in && !(cmd_take && cmd_code_in == CMD_CLS));
    next_poll_valid = serial_poll_in;
    next_poll_data = poll_data_out;
    if (serial_poll_in) begin
      next_poll_data = status_summary_byte_out;
      next_poll_data[`STL_STB_MSS] = srq_out;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      esr <= `STL_ESR_RST;
      ese <= `STL_ESE_RST;
      service_request_mask <= `STL_SRE_RST;
      opc_pend <= 1'b0;
      status_summary_byte_out <= 8'h00;
      srq_out <= 1'b0;
      poll_valid_out <= 1'b0;
      poll_data_out <= 8'h00;
    end else begin
      esr <= next_esr;
      ese <= next_ese;
      service_request_mask <= next_sre;
      opc_pend <= next_opc_pend;
      status_summary_byte_out <= next_stb;
      srq_out <= next_rqs;
      poll_valid_out <= next_poll_valid;
      poll_data_out <= next_poll_data;
    end
  end

  // triggers ignored during wait and self-test so test levels are not clobbered
  assign fire = (state == ST_IDLE) && listener_addr_in && trigger_armed_waiting_out &&
                ((cmd_take && cmd_code_in == CMD_TRG) || bus_trigger_in);
  assign crc_clr = (state == ST_TST_NEG) && (cnt == HOLD_LAST);
  assign crc_en = (state == ST_TST_CRC) && (cnt != '0) && (cnt <= CRC_DATA_END);

  // sequencer, trigger arming, levels and query answers
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_cont = cont;
    next_armed = trigger_armed_waiting_out;
    next_saved_volt = saved_volt;
    next_volt = volt_level_out;
    next_curr = curr_level_out;
    next_apply = 1'b0;
    next_resp_valid = 1'b0;
    next_resp_data = resp_data_out;
    next_nvm_addr = nvm_addr_out;
    next_test_active = test_active_out;
    if (fire) begin
      next_volt = trig_volt_in;
      next_curr = trig_curr_in;
      next_apply = 1'b1;
      next_armed = cont;
    end
    unique case (state)
      ST_IDLE: begin
        if (cmd_take) begin
          unique case (cmd_code_in)
            CMD_ESE_Q: begin
              next_resp_valid = 1'b1;
              next_resp_data = ese;
            end
            CMD_ESR_Q: begin
              next_resp_valid = 1'b1;
              next_resp_data = esr;
            end
            CMD_SRE_Q: begin
              next_resp_valid = 1'b1;
              next_resp_data = service_request_mask;
            end
            CMD_STB_Q: begin
              next_resp_valid = 1'b1;
              next_resp_data = status_summary_byte_out;
            end
            CMD_INIT_CONT_Q: begin
              next_resp_valid = 1'b1;
              next_resp_data = {7'h00, cont};
            end
            CMD_INIT: next_armed = 1'b1;
            CMD_INIT_CONT: begin
              next_cont = cmd_data_in[0];
              if (cmd_data_in[0]) begin
                next_armed = 1'b1;
              end
            end
            CMD_RST: begin
              next_cont = 1'b0;
              next_armed = 1'b0;
              next_volt = '0;
              next_curr = '0;
              next_apply = 1'b1;
            end
            CMD_WAI: begin
              if (busy_all) begin
                next_state = ST_WAIT_DONE;
              end
            end
            CMD_OPC_Q: begin
              if (busy_all) begin
                next_state = ST_OPCQ_WAIT;
              end else begin
                next_resp_valid = 1'b1;
                next_resp_data = `STL_OPCQ_DONE;
              end
            end
            CMD_TST_Q: begin
              next_saved_volt = volt_level_out;
              next_volt = FS_POS;
              next_apply = 1'b1;
              next_cnt = '0;
              next_test_active = 1'b1;
              next_state = ST_TST_POS;
            end
            default: ;
          endcase
        end
      end
      ST_WAIT_DONE: begin
        if (!busy_all) begin
          next_state = ST_IDLE;
        end
      end
      ST_OPCQ_WAIT: begin
        if (!busy_all) begin
          next_resp_valid = 1'b1;
          next_resp_data = `STL_OPCQ_DONE;
          next_state = ST_IDLE;
        end
      end
      ST_TST_POS: begin
        next_cnt = cnt + CNT_W'(1);
        if (cnt == HOLD_LAST) begin
          next_cnt = '0;
          next_volt = FS_NEG;
          next_apply = 1'b1;
          next_state = ST_TST_NEG;
        end
      end
      ST_TST_NEG: begin
        next_cnt = cnt + CNT_W'(1);
        if (cnt == HOLD_LAST) begin
          next_cnt = '0;
          next_nvm_addr = '0;
          next_state = ST_TST_CRC;
        end
      end
      ST_TST_CRC: begin
        // address runs one ahead of the data it returns
        next_cnt = cnt + CNT_W'(1);
        next_nvm_addr = NVM_AW'(cnt + CNT_W'(1));
        if (cnt == CRC_LAST) begin
          next_resp_valid = 1'b1;
          next_resp_data = (crc_val == 8'h00) ? `STL_TST_PASS : `STL_TST_FAIL;
          next_volt = saved_volt;
          next_apply = 1'b1;
          next_test_active = 1'b0;
          next_cnt = '0;
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    next_ready = (next_state == ST_IDLE);
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      state <= ST_IDLE;
      cnt <= '0;
      cont <= 1'b0;
      trigger_armed_waiting_out <= 1'b0;
      saved_volt <= '0;
      volt_level_out <= '0;
      curr_level_out <= '0;
      level_apply_out <= 1'b0;
      resp_valid_out <= 1'b0;
      resp_data_out <= 8'h00;
      cmd_ready_out <= 1'b1;
      nvm_addr_out <= '0;
      test_active_out <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      cont <= next_cont;
      trigger_armed_waiting_out <= next_armed;
      saved_volt <= next_saved_volt;
      volt_level_out <= next_volt;
      curr_level_out <= next_curr;
      level_apply_out <= next_apply;
      resp_valid_out <= next_resp_valid;
      resp_data_out <= next_resp_data;
      cmd_ready_out <= next_ready;
      nvm_addr_out <= next_nvm_addr;
      test_active_out <= next_test_active;
    end
  end

  // memory checksum for the self-test
  stl_crc8 u_crc (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .clr_in(crc_clr),
    .en_in(crc_en),
    .data_in(nvm_data_in),
    .crc_out(crc_val)
  );

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  a_mss_enabled_or: assert property ($stable(service_request_mask) |->
    status_summary_byte_out[6] == |(status_summary_byte_out & service_request_mask & 8'hBF))
    else $error("status bit 6 differs from enabled OR");
  a_sre_bit6_drop: assert property (cmd_take && cmd_code_in == CMD_SRE |=>
    service_request_mask == ($past(cmd_data_in) & 8'hBF))
    else $error("service request mask stored wrongly");
  a_poll_clears_rqs: assert property (serial_poll_in && !mss_rise |=>
    poll_valid_out && poll_data_out[6] == $past(srq_out) && !srq_out)
    else $error("serial poll answer or request clear wrong");
  a_stb_query_keep: assert property (cmd_take && cmd_code_in == CMD_STB_Q |=>
    resp_valid_out && resp_data_out == $past(status_summary_byte_out))
    else $error("status byte query answer wrong");
  a_sre_query: assert property (cmd_take && cmd_code_in == CMD_SRE_Q |=>
    resp_valid_out && resp_data_out == $past(service_request_mask))
    else $error("mask query answer wrong");
  a_esr_read_clear: assert property (cmd_take && cmd_code_in == CMD_ESR_Q && esr_set == 8'h00 |=>
    resp_data_out == $past(esr) && esr == 8'h00)
    else $error("event status not cleared by read");
  a_unknown_cme: assert property (cmd_take && !known |=> esr[5])
    else $error("unknown command did not flag error");
  a_trig_apply: assert property (fire |=> level_apply_out && volt_level_out == $past(trig_volt_in) &&
    trigger_armed_waiting_out == $past(cont))
    else $error("trigger did not apply levels");
  a_unaddr_ignore: assert property (cmd_take && cmd_code_in == CMD_TRG && !listener_addr_in |=>
    !level_apply_out)
    else $error("trigger acted while not listener");
  a_wai_hold: assert property (cmd_take && cmd_code_in == CMD_WAI && ops_busy_in |=>
    !cmd_ready_out)
    else $error("wait command did not hold commands");
  a_test_full_scale: assert property (cmd_take && cmd_code_in == CMD_TST_Q |=>
    volt_level_out == FS_POS && test_active_out)
    else $error("self-test did not drive full scale");
  a_opc_sets_bit0: assert property (opc_pend && !busy_all |=> esr[0])
    else $error("operation complete bit not set");

  c_trigger_fire: cover property (fire ##1 level_apply_out);
  c_poll_with_rqs: cover property (srq_out && serial_poll_in);
  c_selftest_done: cover property (state == ST_TST_CRC ##1 resp_valid_out);
  c_wai_released: cover property (state == ST_WAIT_DONE ##1 cmd_ready_out);

endmodule : stl_status_trigger

// file: tb/stl_ctrl_model.sv
`timescale 1ns/1ns
// bus controller side: issues common commands, serial polls and group triggers
module stl_ctrl_model (
  input wire logic sys_clk_in, // system clock
  input wire logic cmd_ready_in, // device takes the command
  output logic cmd_valid_out, // command present
  output logic [4:0] cmd_code_out, // command code
  output logic [7:0] cmd_data_out, // argument byte
  output logic serial_poll_out, // serial poll pulse
  output logic bus_trigger_out // group execute trigger pulse
);
  initial begin
    cmd_valid_out = 1'b0;
    cmd_code_out = 5'h00;
    cmd_data_out = 8'h00;
    serial_poll_out = 1'b0;
    bus_trigger_out = 1'b0;
  end

  // request held until ready is seen high at an edge or 200 more edges pass, so a busy device stalls us
  task send(input logic [4:0] code, input logic [7:0] data);
    int n;
    @(posedge sys_clk_in);
    #2;
    cmd_valid_out = 1'b1;
    cmd_code_out = code;
    cmd_data_out = data;
    n = 0;
    @(posedge sys_clk_in);
    while (cmd_ready_in !== 1'b1 && n < 200) begin
      @(posedge sys_clk_in);
      n++;
    end
    #2;
    cmd_valid_out = 1'b0;
    // released lines carry the inverse, never a stale copy
    cmd_code_out = ~code;
    cmd_data_out = ~data;
  endtask : send

  // one-cycle pulse: sel low polls, sel high triggers
  task pulse(input logic sel);
    @(posedge sys_clk_in);
    #2;
    serial_poll_out = ~sel;
    bus_trigger_out = sel;
    @(posedge sys_clk_in);
    #2;
    serial_poll_out = 1'b0;
    bus_trigger_out = 1'b0;
  endtask : pulse
endmodule : stl_ctrl_model

// file: tb/stl_status_trigger_tb_top.sv
`timescale 1ns/1ns
module stl_status_trigger_tb_top import stl_pkg::*;;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic listener = 1'b0;
  logic ops_busy = 1'b0;
  logic [2:0] err = 3'b000;
  logic [3:0] lv = 4'h0;
  logic [15:0] vt = 16'h0000;
  logic [15:0] ct = 16'h0000;
  logic [7:0] nvm_q = 8'h00;
  logic [7:0] mem [0:7];
  logic cmd_valid, cmd_ready, poll, gtrig, resp_valid, poll_valid, armed, apply, t_act, srq;
  logic [4:0] cmd_code;
  logic [7:0] cmd_data, resp_data, poll_data, stb;
  logic [2:0] nvm_addr;
  logic [15:0] volt, curr;
  logic [7:0] expq [$];
  int bad_count = 0;
  int compares = 0;
  int seed = 57;

  initial forever #25 sys_clk = ~sys_clk;

  stl_ctrl_model ctrl (.sys_clk_in(sys_clk), .cmd_ready_in(cmd_ready), .cmd_valid_out(cmd_valid),
    .cmd_code_out(cmd_code), .cmd_data_out(cmd_data), .serial_poll_out(poll), .bus_trigger_out(gtrig));

  stl_status_trigger #(.NVM_DEPTH(8), .NVM_AW(3), .FS_HOLD_CYCLES(4)) dut (.sys_clk_in(sys_clk),
    .rst_n_in(rst_n), .cmd_valid_in(cmd_valid), .cmd_code_in(cmd_code), .cmd_data_in(cmd_data),
    .cmd_ready_out(cmd_ready), .listener_addr_in(listener), .bus_trigger_in(gtrig), .serial_poll_in(poll),
    .ops_busy_in(ops_busy), .exec_error_in(err[0]), .dev_error_in(err[1]), .query_error_in(err[2]),
    .operation_summary_in(lv[3]), .msg_avail_in(lv[2]), .questionable_summary_in(lv[1]),
    .error_queue_nonempty_in(lv[0]), .trig_volt_in(vt), .trig_curr_in(ct), .nvm_data_in(nvm_q),
    .nvm_addr_out(nvm_addr), .resp_valid_out(resp_valid), .resp_data_out(resp_data),
    .poll_valid_out(poll_valid), .poll_data_out(poll_data), .status_summary_byte_out(stb), .srq_out(srq),
    .trigger_armed_waiting_out(armed), .volt_level_out(volt), .curr_level_out(curr),
    .level_apply_out(apply), .test_active_out(t_act));

  // memory answers one cycle after the address
  always @(posedge sys_clk) nvm_q <= mem[nvm_addr];

  task check(input logic [15:0] seen, input logic [15:0] want);
    compares++;
    if (seen !== want) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task print_verdict();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  task wt(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask : wt

  // note the answer first, then issue the query
  task q(input logic [4:0] code, input logic [7:0] data, input logic [7:0] want);
    expq.push_back(want);
    ctrl.send(code, data);
  endtask : q

  // expected status byte; bit 6 is never part of its own summary
  function automatic logic [7:0] exp_stb(input logic [3:0] l, input logic esb, input logic [7:0] service_request_mask);
    logic [7:0] b;
    b = {l[3], 1'b0, esb, l[2], l[1], l[0], 2'b00};
    b[6] = |(b & service_request_mask & 8'hBF);
    return b;
  endfunction : exp_stb

  // answers are matched against the oldest note in arrival order
  always @(posedge sys_clk) begin
    if (resp_valid === 1'b1 || poll_valid === 1'b1) begin
      if (expq.size() == 0) begin
        bad_count++;
        $display("[FAIL] %0t answer with nothing expected", $time);
      end else check({8'h00, (resp_valid === 1'b1) ? resp_data : poll_data}, {8'h00, expq.pop_front()});
    end
  end

  initial begin
    #(5000 * 50);
    bad_count++;
    print_verdict();
  end

  initial begin
    for (int i = 0; i < 8; i++) mem[i] = 8'h00;
    wt(4);
    rst_n = 1'b1;
    q(CMD_ESR_Q, 8'h00, 8'h80);
    q(CMD_ESR_Q, 8'h00, 8'h00);
    q(CMD_STB_Q, 8'h00, 8'h00);
    // enabled command error feeds the event summary, then the master summary
    ctrl.send(CMD_ESE, 8'h20);
    q(CMD_ESE_Q, 8'h00, 8'h20);
    ctrl.send(CMD_SRE, 8'h20);
    ctrl.send(5'h1F, 8'h00);
    err = 3'b111;
    wt(1);
    err = 3'b000;
    wt(4);
    check({8'h00, stb}, 16'h0060);
    check({15'h0000, srq}, 16'h0001);
    q(CMD_STB_Q, 8'h00, 8'h60);
    expq.push_back(8'h60);
    ctrl.pulse(1'b0);
    expq.push_back(8'h20);
    ctrl.pulse(1'b0);
    q(CMD_STB_Q, 8'h00, 8'h60);
    q(CMD_ESR_Q, 8'h00, 8'h3C);
    wt(4);
    q(CMD_STB_Q, 8'h00, 8'h00);
    ctrl.send(CMD_SRE, 8'hFF);
    q(CMD_SRE_Q, 8'h00, 8'hBF);
    // random condition levels, ending all clear so a latched summary shows
    for (int i = 0; i < 5; i++) begin
      lv = (i == 4) ? 4'h0 : 4'($random(seed));
      wt(3);
      q(CMD_STB_Q, 8'h00, exp_stb(lv, 1'b0, 8'hBF));
    end
    // clear status drops the event summary and the request flag
    ctrl.send(5'h1F, 8'h00);
    wt(3);
    check({15'h0000, srq}, 16'h0001);
    ctrl.send(CMD_CLS, 8'h00);
    wt(3);
    check({15'h0000, srq}, 16'h0000);
    q(CMD_STB_Q, 8'h00, 8'h00);
    // triggers: ignored unless addressed, single arming fires once
    vt = 16'($random(seed));
    ct = 16'($random(seed));
    ctrl.send(CMD_INIT, 8'h00);
    ctrl.send(CMD_TRG, 8'h00);
    wt(2);
    check(volt, 16'h0000);
    check({15'h0000, armed}, 16'h0001);
    listener = 1'b1;
    ctrl.send(CMD_TRG, 8'h00);
    check({15'h0000, apply}, 16'h0001);
    wt(2);
    check(volt, vt);
    check(curr, ct);
    check({15'h0000, armed}, 16'h0000);
    vt = ~vt;
    ctrl.send(CMD_TRG, 8'h00);
    wt(2);
    check(volt, ~vt);
    ctrl.send(CMD_INIT_CONT, 8'h01);
    q(CMD_INIT_CONT_Q, 8'h00, 8'h01);
    ctrl.pulse(1'b1);
    wt(2);
    check(volt, vt);
    check({15'h0000, armed}, 16'h0001);
    ctrl.send(CMD_RST, 8'h00);
    wt(2);
    check(volt, 16'h0000);
    check({15'h0000, armed}, 16'h0000);
    q(CMD_INIT_CONT_Q, 8'h00, 8'h00);
    // completion tracking and the wait gate
    ops_busy = 1'b1;
    ctrl.send(CMD_OPC, 8'h00);
    ctrl.send(CMD_WAI, 8'h00);
    wt(3);
    check({15'h0000, cmd_ready}, 16'h0000);
    ops_busy = 1'b0;
    q(CMD_ESR_Q, 8'h00, 8'h01);
    q(CMD_OPC_Q, 8'h00, 8'h01);
    // self-test on clean then damaged memory
    q(CMD_TST_Q, 8'h00, 8'h00);
    wt(2);
    check({15'h0000, t_act}, 16'h0001);
    check(volt, 16'h7FFF);
    wt(4);
    check(volt, 16'h8000);
    // memory may only be damaged once the first checksum pass is over
    wt(16);
    mem[3] = 8'h5A;
    q(CMD_TST_Q, 8'h00, 8'h01);
    for (int i = 0; i < 100 && expq.size() > 0; i++) wt(1);
    check({15'h0000, expq.size() == 0}, 16'h0001);
    print_verdict();
  end
endmodule : stl_status_trigger_tb_top
